// file: ec_control_two.sv
// Purpose: second control register of one canceller group, copies A and B
// Assumes: host port with one-cycle strobes, read data one cycle later
// Notes:
// Notes on behaviour
// - reversal qualification off: any 2100 Hz fires
// - qualification on: only phase-reversing tone fires
// - filter-off bit bypasses both input high-pass filters
// - filter on removes dc on both inputs
// - gated flag needs automatic bypass and tone
//
// Chosen here: the address-and-strobe port.
`include "ec_control_two_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module ec_control_two
    import ec_control_two_pkg::*;
#(
    parameter int PAIR_MIN = `PAIR_MIN_CYCLES,
    parameter int PAIR_MAX = `PAIR_MAX_CYCLES
) (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RESET,
    // register port
    input wire logic [5:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // tone detector indications, canceller a then b
    input wire logic i_a_tone_present,
    input wire logic i_a_phase_reversal_seen,
    input wire logic i_b_tone_present,
    input wire logic i_b_phase_reversal_seen,
    // sample streams, canceller a
    input wire logic i_a_valid,
    input wire sample_t i_a_rin,
    input wire sample_t i_a_sin,
    output sample_t o_a_rout,
    output sample_t o_a_sout,
    // sample streams, canceller b
    input wire logic i_b_valid,
    input wire sample_t i_b_rin,
    input wire sample_t i_b_sin,
    output sample_t o_b_rout,
    output sample_t o_b_sout,
    // control levels to the canceller cores
    output logic O_A_TONE_DISABLE_CTL,
    output logic O_A_NONLINEAR_PROCESSOR_OFF,
    output logic O_A_NARROWBAND_DETECTOR_OFF,
    output logic O_B_TONE_DISABLE_CTL,
    output logic O_B_NONLINEAR_PROCESSOR_OFF,
    output logic O_B_NARROWBAND_DETECTOR_OFF,
    // gated tone flags
    output logic o_a_gated_tone_flag,
    output logic o_b_gated_tone_flag
);
    // register state, pair tracking and registered read data
    logic [7:0] canceller_a_control_two, next_a;
    logic [7:0] canceller_b_control_two, next_b;
    logic [7:0] pending, next_pending;
    logic [15:0] gap, next_gap;
    pair_state_e pair_state, next_pair_state;
    logic [7:0] rdata, next_rdata;
    logic a_tone, b_tone, a_gated, b_gated;

    // one decoder for every strobe, so a read and a write agree on what hits
    function automatic logic hit(input logic strobe, input logic [5:0] addr, input logic [5:0] target);
        hit = strobe && (addr == target);
    endfunction

    // both ends of the pairing window are inclusive
    function automatic logic in_window(input logic [15:0] count);
        in_window = (32'(count) >= PAIR_MIN) && (32'(count) <= PAIR_MAX);
    endfunction

    // reserved status bits read as zero
    function automatic logic [7:0] status_byte(input logic tone, input logic gated);
        status_byte = 8'h00;
        status_byte[`BIT_STATUS_TONE] = tone;
        status_byte[`BIT_STATUS_GATED_TONE] = gated;
    endfunction

    // canceller a commits on a single write
    always_comb begin
        next_a = canceller_a_control_two;
        if (hit(i_wr, i_addr, `ADDR_CANCELLER_A_CONTROL_TWO)) begin
            next_a = i_wdata;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            canceller_a_control_two <= `RESET_CONTROL_TWO;
        end else begin
            canceller_a_control_two <= next_a;
        end
    end

    // canceller b takes a value only when confirmed by an identical second write
    always_comb begin
        next_b = canceller_b_control_two;
        next_pending = pending;
        next_pair_state = pair_state;
        next_gap = gap;
        // the count saturates so a stalled pair can never wrap back into the window
        if (pair_state == PAIR_ARMED && gap != 16'hffff) begin
            next_gap = gap + 16'h0001;
        end
        case (pair_state)
            PAIR_IDLE: begin
                if (hit(i_wr, i_addr, `ADDR_CANCELLER_B_CONTROL_TWO)) begin
                    next_pending = i_wdata;
                    next_pair_state = PAIR_ARMED;
                    next_gap = 16'h0001;
                end
            end
            PAIR_ARMED: begin
                if (hit(i_wr, i_addr, `ADDR_CANCELLER_B_CONTROL_TWO)) begin
                    if (i_wdata == pending && in_window(gap)) begin
                        next_b = i_wdata;
                        next_pair_state = PAIR_IDLE;
                    end else begin
                        // a bad second write starts a fresh pair
                        next_pending = i_wdata;
                        next_gap = 16'h0001;
                    end
                end else if (i_wr) begin
                    // any other write breaks the back-to-back sequence
                    next_pair_state = PAIR_IDLE;
                end else if (32'(gap) > PAIR_MAX) begin
                    next_pair_state = PAIR_IDLE;
                end
            end
            default: begin
                next_pair_state = PAIR_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            canceller_b_control_two <= `RESET_CONTROL_TWO;
            pending <= 8'h00;
            gap <= 16'h0000;
            pair_state <= PAIR_IDLE;
        end else begin
            canceller_b_control_two <= next_b;
            pending <= next_pending;
            gap <= next_gap;
            pair_state <= next_pair_state;
        end
    end

    // reads: unmapped addresses answer zero
    always_comb begin
        next_rdata = 8'h00;
        if (hit(i_rd, i_addr, `ADDR_CANCELLER_A_CONTROL_TWO)) begin
            next_rdata = canceller_a_control_two;
        end else if (hit(i_rd, i_addr, `ADDR_CANCELLER_B_CONTROL_TWO)) begin
            next_rdata = canceller_b_control_two;
        end else if (hit(i_rd, i_addr, `ADDR_CANCELLER_A_STATUS)) begin
            next_rdata = status_byte(a_tone, a_gated);
        end else if (hit(i_rd, i_addr, `ADDR_CANCELLER_B_STATUS)) begin
            next_rdata = status_byte(b_tone, b_gated);
        end
    end

    // read data stands for one cycle only, then falls back to zero
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

    assign o_rdata = rdata;

    // the two sample paths are alike; each takes its own control byte, tone indications and sample streams
    ec_sample_path path_a (
        .I_CLK(I_CLK),
        .I_RESET(I_RESET),
        .i_control(canceller_a_control_two),
        .i_tone_present(i_a_tone_present),
        .i_phase_reversal_seen(i_a_phase_reversal_seen),
        .i_valid(i_a_valid),
        .i_rin(i_a_rin),
        .i_sin(i_a_sin),
        .o_rout(o_a_rout),
        .o_sout(o_a_sout),
        .o_tone_detect(a_tone),
        .o_gated_tone_flag(a_gated)
    );

    ec_sample_path path_b (
        .I_CLK(I_CLK),
        .I_RESET(I_RESET),
        .i_control(canceller_b_control_two),
        .i_tone_present(i_b_tone_present),
        .i_phase_reversal_seen(i_b_phase_reversal_seen),
        .i_valid(i_b_valid),
        .i_rin(i_b_rin),
        .i_sin(i_b_sin),
        .o_rout(o_b_rout),
        .o_sout(o_b_sout),
        .o_tone_detect(b_tone),
        .o_gated_tone_flag(b_gated)
    );

    assign o_a_gated_tone_flag = a_gated;
    assign o_b_gated_tone_flag = b_gated;

    // the cores see a new level in the cycle after the write lands
    assign O_A_TONE_DISABLE_CTL = canceller_a_control_two[`BIT_TONE_DISABLE_CTL];
    assign O_A_NONLINEAR_PROCESSOR_OFF = canceller_a_control_two[`BIT_NONLINEAR_PROCESSOR_OFF];
    assign O_A_NARROWBAND_DETECTOR_OFF = canceller_a_control_two[`BIT_NARROWBAND_DETECTOR_OFF];
    assign O_B_TONE_DISABLE_CTL = canceller_b_control_two[`BIT_TONE_DISABLE_CTL];
    assign O_B_NONLINEAR_PROCESSOR_OFF = canceller_b_control_two[`BIT_NONLINEAR_PROCESSOR_OFF];
    assign O_B_NARROWBAND_DETECTOR_OFF = canceller_b_control_two[`BIT_NARROWBAND_DETECTOR_OFF];
endmodule
`default_nettype wire

// file: ec_control_two_defines.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 50 MHz clock
// Notes: included by every module file; the package holds only types
`ifndef EC_CONTROL_TWO_DEFINES_SVH
`define EC_CONTROL_TWO_DEFINES_SVH
`define ADDR_CANCELLER_A_CONTROL_TWO 6'h01
`define ADDR_CANCELLER_A_STATUS 6'h02
`define ADDR_CANCELLER_B_CONTROL_TWO 6'h21
`define ADDR_CANCELLER_B_STATUS 6'h22
`define RESET_CONTROL_TWO 8'h00
`define BIT_TONE_DISABLE_CTL 7
`define BIT_PHASE_REVERSAL_QUAL_OFF 6
`define BIT_NONLINEAR_PROCESSOR_OFF 5
`define BIT_AUTOMATIC_TONE_BYPASS 4
`define BIT_NARROWBAND_DETECTOR_OFF 3
`define BIT_OFFSET_NULLING_FILTER_OFF 2
`define BIT_SEND_OUTPUT_SILENCE 1
`define BIT_RECEIVE_OUTPUT_SILENCE 0
`define BIT_STATUS_TONE 6
`define BIT_STATUS_GATED_TONE 1
`define CLK_PERIOD_NS 20
`define PAIR_MIN_NS 350
`define PAIR_MAX_NS 20000
`define PAIR_MIN_CYCLES ((`PAIR_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PAIR_MAX_CYCLES (`PAIR_MAX_NS / `CLK_PERIOD_NS)
`define QUIET_CODE 8'hff
`endif

// file: ec_control_two_pkg.sv
// Purpose: shared types for the control-two register bank
// Assumes: nothing
// Notes: constants live in the defines header
package ec_control_two_pkg;
    typedef enum logic [1:0] {
        PAIR_IDLE,
        PAIR_ARMED
    } pair_state_e;
    typedef logic [7:0] sample_t;
endpackage

// file: ec_sample_path.sv
// Purpose: per-canceller sample path: offset nulling, tone gating and muting
// Assumes: one sample per i_*_valid pulse
// Notes: first-order dc-removal high-pass on signed 8-bit linear samples
`include "ec_control_two_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module ec_sample_path
    import ec_control_two_pkg::*;
#(
    parameter int HPF_SHIFT = 4
) (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RESET,
    // control bits
    input wire logic [7:0] i_control,
    // tone detector raw indications
    input wire logic i_tone_present,
    input wire logic i_phase_reversal_seen,
    // samples in
    input wire logic i_valid,
    input wire sample_t i_rin,
    input wire sample_t i_sin,
    // samples out
    output sample_t o_rout,
    output sample_t o_sout,
    output logic o_tone_detect,
    output logic o_gated_tone_flag
);
    logic signed [15:0] rin_dc, sin_dc, next_rin_dc, next_sin_dc;
    sample_t rout, sout, next_rout, next_sout;
    logic tone, next_tone;

    function automatic sample_t hpf_out(input sample_t x, input logic signed [15:0] dc);
        logic signed [15:0] d;
        d = 16'($signed({{8{x[7]}}, x})) - (dc >>> HPF_SHIFT);
        if (d > 16'sd127) begin
            hpf_out = 8'h7f;
        end else if (d < -16'sd128) begin
            hpf_out = 8'h80;
        end else begin
            hpf_out = d[7:0];
        end
    endfunction

    function automatic logic signed [15:0] dc_step(input sample_t x, input logic signed [15:0] dc);
        dc_step = dc + 16'($signed({{8{x[7]}}, x})) - (dc >>> HPF_SHIFT);
    endfunction

    always_comb begin
        next_rin_dc = rin_dc;
        next_sin_dc = sin_dc;
        next_rout = rout;
        next_sout = sout;
        // without reversal qualification any 2100 Hz tone fires
        next_tone = i_tone_present && (i_control[`BIT_PHASE_REVERSAL_QUAL_OFF] || i_phase_reversal_seen);
        if (i_valid) begin
            if (i_control[`BIT_OFFSET_NULLING_FILTER_OFF]) begin
                next_rout = i_rin;
                next_sout = i_sin;
            end else begin
                next_rin_dc = dc_step(i_rin, rin_dc);
                next_sin_dc = dc_step(i_sin, sin_dc);
                next_rout = hpf_out(i_rin, rin_dc);
                next_sout = hpf_out(i_sin, sin_dc);
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            rin_dc <= '0;
            sin_dc <= '0;
            rout <= '0;
            sout <= '0;
            tone <= 1'b0;
        end else begin
            rin_dc <= next_rin_dc;
            sin_dc <= next_sin_dc;
            rout <= next_rout;
            sout <= next_sout;
            tone <= next_tone;
        end
    end

    // muting is applied after the register so a mute change acts at once
    assign o_rout = i_control[`BIT_RECEIVE_OUTPUT_SILENCE] ? `QUIET_CODE : rout;
    assign o_sout = i_control[`BIT_SEND_OUTPUT_SILENCE] ? `QUIET_CODE : sout;
    assign o_tone_detect = tone;
    assign o_gated_tone_flag = tone && i_control[`BIT_AUTOMATIC_TONE_BYPASS];
endmodule
`default_nettype wire

// file: ec_control_two_checker.sv
// Purpose: port checker for the control-two bank
// Assumes: canceller A copy tracked from host writes
// Notes: B copy needs the pairing history, left to the bench
`include "ec_control_two_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module ec_control_two_checker
    import ec_control_two_pkg::*;
(
    // clock and bus
    input wire logic I_CLK,
    input wire logic I_RESET,
    input wire logic [5:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    // canceller a
    input wire logic i_a_tone_present,
    input wire logic i_a_phase_reversal_seen,
    input wire logic i_a_valid,
    input wire sample_t i_a_rin,
    input wire sample_t i_a_sin,
    input wire sample_t o_a_rout,
    input wire sample_t o_a_sout,
    input wire logic o_a_gated_tone_flag
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);
    logic [7:0] ctl;
    logic [7:0] next_ctl;
    always_comb begin
        next_ctl = ctl;
        if (i_wr && i_addr == `ADDR_CANCELLER_A_CONTROL_TWO) begin
            next_ctl = i_wdata;
        end
        if (I_RESET) begin
            next_ctl = `RESET_CONTROL_TWO;
        end
    end
    always_ff @(posedge I_CLK) begin
        ctl <= next_ctl;
    end
    sequence s_any_tone;
        ctl[6] && i_a_tone_present ##1 ctl[4];
    endsequence
    sequence s_reversing_tone;
        i_a_tone_present && i_a_phase_reversal_seen ##1 ctl[4];
    endsequence
    a_tone_any: assert property (s_any_tone |-> o_a_gated_tone_flag) else $error("tone not flagged");
    a_tone_rev: assert property (s_reversing_tone |-> o_a_gated_tone_flag) else $error("reversal tone missed");
    a_rev_needed: assert property ((!ctl[6] && !i_a_phase_reversal_seen) ##1 1'b1 |-> !o_a_gated_tone_flag)
        else $error("plain tone flagged");
    a_gate_bypass: assert property (!ctl[4] |-> !o_a_gated_tone_flag) else $error("flag without bypass");
    a_rin_bypass: assert property (ctl[2] && i_a_valid ##1 !ctl[0] |-> o_a_rout == $past(i_a_rin))
        else $error("rin not bypassed");
    a_sin_bypass: assert property (ctl[2] && i_a_valid ##1 !ctl[1] |-> o_a_sout == $past(i_a_sin))
        else $error("sin not bypassed");
    a_send_mute: assert property (ctl[1] |-> o_a_sout == `QUIET_CODE) else $error("send not muted");
    a_recv_mute: assert property (ctl[0] |-> o_a_rout == `QUIET_CODE) else $error("receive not muted");
    a_read_back: assert property (i_rd && i_addr == `ADDR_CANCELLER_A_CONTROL_TWO |=> o_rdata == $past(ctl))
        else $error("read back wrong");
    a_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00) else $error("read data held too long");
endmodule
bind ec_control_two ec_control_two_checker chk (.I_CLK, .I_RESET, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_a_tone_present, .i_a_phase_reversal_seen, .i_a_valid, .i_a_rin, .i_a_sin, .o_a_rout, .o_a_sout,
    .o_a_gated_tone_flag);
`default_nettype wire

// file: ec_host_model.sv
// Purpose: host processor on the register port
// Assumes: one-cycle strobes, read data in the next cycle
// Notes: released write data is inverted so stale values never pass
`include "ec_control_two_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module ec_host_model (
    // clock and read data
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    // request
    output logic [5:0] o_addr,
    output logic [7:0] o_wdata,
    output logic o_wr,
    output logic o_rd
);
    initial begin
        o_addr = 6'h00;
        o_wdata = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    task automatic write(input logic [5:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_wdata <= ~d;
    endtask
    task automatic read(input logic [5:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        // the answer stands only in this cycle
        @(negedge i_clk);
        d = i_rdata;
    endtask
    // gap counts edges between the two take edges
    task automatic write_b(input logic [7:0] d, input int gap);
        write(`ADDR_CANCELLER_B_CONTROL_TWO, d);
        repeat (gap - 2) @(posedge i_clk);
        write(`ADDR_CANCELLER_B_CONTROL_TWO, d);
    endtask
endmodule
`default_nettype wire

// file: echo_canceller_control_two_tb_top.sv
// Purpose: self-checking bench for the control-two bank
// Assumes: pairing window shortened to 40 cycles
// Notes: both cancellers share one stimulus
`include "ec_control_two_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module echo_canceller_control_two_tb_top;
    import ec_control_two_pkg::*;
    localparam int PMAX = 40;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] addr;
    logic [7:0] wdata, rdata, got;
    logic wr, rd;
    logic tone = 1'b0, phrev = 1'b0, valid = 1'b0;
    sample_t rin = 8'h00, sin = 8'h00, a_rout, a_sout, b_rout, b_sout;
    logic [5:0] lv;
    logic [1:0] flag;
    int errors = 0, comparisons = 0, cycles = 0;
    always #10 clk = ~clk;
    ec_host_model host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
    ec_control_two #(.PAIR_MAX(PMAX)) dut (.I_CLK(clk), .I_RESET(rst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_a_tone_present(tone), .i_a_phase_reversal_seen(phrev),
        .i_b_tone_present(tone), .i_b_phase_reversal_seen(phrev), .i_a_valid(valid), .i_a_rin(rin),
        .i_a_sin(sin), .o_a_rout(a_rout), .o_a_sout(a_sout), .i_b_valid(valid), .i_b_rin(rin), .i_b_sin(sin),
        .o_b_rout(b_rout), .o_b_sout(b_sout), .O_A_TONE_DISABLE_CTL(lv[5]), .O_A_NONLINEAR_PROCESSOR_OFF(lv[4]),
        .O_A_NARROWBAND_DETECTOR_OFF(lv[3]), .O_B_TONE_DISABLE_CTL(lv[2]), .O_B_NONLINEAR_PROCESSOR_OFF(lv[1]),
        .O_B_NARROWBAND_DETECTOR_OFF(lv[0]), .o_a_gated_tone_flag(flag[1]), .o_b_gated_tone_flag(flag[0]));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            errors++;
            give_verdict();
        end
    end
    task automatic sample(input sample_t r, input sample_t s);
        @(posedge clk);
        valid <= 1'b1;
        rin <= r;
        sin <= s;
        @(posedge clk);
        valid <= 1'b0;
        @(negedge clk);
    endtask
    task automatic t_reset;
        logic [5:0] adrs [5] = '{6'h01, 6'h21, 6'h02, 6'h22, 6'h3f};
        host.write(6'h3f, 8'hff);
        for (int i = 0; i < 5; i++) begin
            host.read(adrs[i], got);
            chk("reset value", 8'h00, got);
        end
    endtask
    task automatic t_pair;
        host.write(6'h01, 8'ha8);
        host.write_b(8'ha8, 17);
        repeat (PMAX + 2) @(posedge clk);
        host.read(6'h21, got);
        chk("b early pair", 8'h00, got);
        host.write_b(8'ha8, 18);
        host.read(6'h21, got);
        chk("b committed", 8'ha8, got);
        chk("levels", 8'h3f, {2'b00, lv});
        host.write_b(8'h00, PMAX + 1);
        repeat (PMAX + 2) @(posedge clk);
        host.read(6'h21, got);
        chk("b late pair", 8'ha8, got);
        host.write_b(8'h00, PMAX);
        host.read(6'h21, got);
        chk("b last edge", 8'h00, got);
        chk("levels b off", 8'h38, {2'b00, lv});
    endtask
    task automatic t_samples;
        host.write(6'h01, 8'h04);
        sample(8'h33, 8'h44);
        chk("rout bypass", 8'h33, a_rout);
        chk("sout bypass", 8'h44, a_sout);
        host.write(6'h01, 8'h03);
        @(negedge clk);
        chk("rout muted", `QUIET_CODE, a_rout);
        chk("sout muted", `QUIET_CODE, a_sout);
        chk("b rout live", 8'h33, b_rout);
        chk("b sout live", 8'h44, b_sout);
        host.write(6'h01, 8'h00);
        repeat (20) sample(8'h40, 8'h40);
        chk("rout nulled", 8'h01, {7'h00, $signed(a_rout) > 0 && $signed(a_rout) < 64});
        chk("sout nulled", 8'h01, {7'h00, $signed(a_sout) > 0 && $signed(a_sout) < 64});
        chk("b rout nulled", 8'h01, {7'h00, $signed(b_rout) > 0 && $signed(b_rout) < 64});
        chk("b sout nulled", 8'h01, {7'h00, $signed(b_sout) > 0 && $signed(b_sout) < 64});
    endtask
    task automatic t_tone;
        // control, tone, reversal, qualified, gated
        logic [11:0] tab [5] = '{{8'h10, 4'b1000}, {8'h10, 4'b1111}, {8'h50, 4'b1011}, {8'h40, 4'b1110},
            {8'h50, 4'b0100}};
        for (int i = 0; i < 5; i++) begin
            host.write(6'h01, tab[i][11:4]);
            tone <= tab[i][3];
            phrev <= tab[i][2];
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk("gated flag", {7'h00, tab[i][0]}, {7'h00, flag[1]});
            chk("gated flag b", 8'h00, {7'h00, flag[0]});
            host.read(6'h02, got);
            chk("status a", {1'b0, tab[i][1], 4'h0, tab[i][0], 1'b0}, got);
            host.read(6'h22, got);
            chk("status b", {1'b0, tab[i][3] & tab[i][2], 6'h00}, got);
        end
        host.write_b(8'h10, 20);
        tone <= 1'b1;
        phrev <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("gated flag b", 8'h01, {7'h00, flag[0]});
        host.read(6'h22, got);
        chk("status b", 8'h42, got);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_pair();
        t_samples();
        t_tone();
        give_verdict();
    end
endmodule
`default_nettype wire
